/* File: fcr_defs.svh */
// register indices, byte addresses, field positions and reset values
`ifndef FCR_DEFS_SVH
`define FCR_DEFS_SVH
`define FCR_IDX_BRAKE     8'h8a
`define FCR_IDX_MOTOR     8'h8c
`define FCR_IDX_SPEED     8'h8e
`define FCR_ADDR_BRAKE    {2'h0, `FCR_IDX_BRAKE, 2'h0}
`define FCR_ADDR_MOTOR    {2'h0, `FCR_IDX_MOTOR, 2'h0}
`define FCR_ADDR_SPEED    {2'h0, `FCR_IDX_SPEED, 2'h0}
`define FCR_RST_VAL       32'h00000000
`define FCR_BRK_LVL_MSB   19
`define FCR_BRK_LVL_LSB   16
`define FCR_RES_MSB       15
`define FCR_RES_LSB       8
`define FCR_IND_MSB       7
`define FCR_IND_LSB       0
`define FCR_BEMF_MSB      30
`define FCR_BEMF_LSB      23
`define FCR_CKP_MSB       22
`define FCR_CKP_LSB       13
`define FCR_CKI_MSB       12
`define FCR_CKI_LSB       3
`define FCR_SKP_HI_MSB    2
`define FCR_SKP_HI_LSB    0
`define FCR_SKP_LO_MSB    30
`define FCR_SKP_LO_LSB    24
`define FCR_SKI_MSB       23
`define FCR_SKI_LSB       14
`define FCR_MAXSPD_MSB    13
`define FCR_MAXSPD_LSB    0
`define FCR_PERMILLE_FULL 24'h0003e8
`define FCR_HZ_DIV        14'h0006
`define FCR_HSIZE_WORD    3'h2
`endif

/* File: fcr_pkg.sv */
// types shared by the closed-loop configuration registers
`default_nettype none
package fcr_pkg;
	typedef enum logic [1:0] {
		FCR_NONE,
		FCR_BRAKE,
		FCR_MOTOR,
		FCR_SPEED
	} fcr_reg_e;

	// gain code: value = mant / 10^exp, times a per-field scale
	typedef struct packed {
		logic [1:0] exp;
		logic [7:0] mant;
	} fcr_gain_s;

	typedef struct packed {
		logic [3:0]  brake_level;
		logic [9:0]  brake_permille;
		logic [13:0] brake_speed_thr;
		logic [7:0]  phase_resistance_code;
		logic [7:0]  phase_inductance_code;
		logic [7:0]  back_emf_constant_code;
		fcr_gain_s   current_loop_prop_gain;
		fcr_gain_s   current_loop_int_gain;
		logic        curr_gain_auto;
		fcr_gain_s   speed_loop_prop_gain;
		fcr_gain_s   speed_loop_int_gain;
		logic [13:0] max_speed;
		logic [11:0] max_speed_hz;
	} fcr_cfg_s;

	typedef struct packed {
		logic [31:0] brake;
		logic [31:0] motor;
		logic [31:0] speed;
		fcr_reg_e    wr_sel;
		logic [31:0] rdata;
	} fcr_state_s;
endpackage
`default_nettype wire

/* File: fcr_regs.sv */
// ahb-lite register bank for closed-loop motor configuration
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "fcr_defs.svh"

// Notes on behaviour
// - brake level code 0..f selects 100 down to 2.5 percent of top speed
// - bits 15..8 of brake register store phase resistance code as written
// - bits 7..0 of brake register store phase inductance code as written
// - bits 30..23 of motor register hold the back-emf constant code
// - current prop gain: low 8 bits over ten to the top 2 bits
// - current int gain: 1000 times low 8 bits over ten to top bits
// - zero current gain fields select automatic current gain calculation
// - motor register bits 2..0 hold speed prop gain top 3 bits
// - motor and speed registers reset to all zeros
// - speed register bits 30..24 hold speed prop gain low 7 bits
// - speed int gain: 0.1 times low 8 bits over ten to top bits
// - 14-bit top speed limit gives electrical hertz as value over six
module fcr_regs (
	input  wire logic          hclk,
	input  wire logic          hresetn,
	input  wire logic          hsel,
	input  wire logic [31:0]   haddr,
	input  wire logic [1:0]    htrans,
	input  wire logic          hwrite,
	input  wire logic [2:0]    hsize,
	input  wire logic [31:0]   hwdata,
	input  wire logic          hready,
	output logic               hreadyout,
	output logic               hresp,
	output logic [31:0]        hrdata,
	output fcr_pkg::fcr_cfg_s  cfg
);

	////////////////////////////////////////////////////////////////////////////
	// brake threshold table, in tenths of a percent
	logic [9:0] perm_tab [16];

	localparam logic [159:0] PERM_PACK = {
		10'h019, 10'h032, 10'h064, 10'h096,
		10'h0c8, 10'h0fa, 10'h12c, 10'h15e,
		10'h190, 10'h1c2, 10'h1f4, 10'h258,
		10'h2bc, 10'h320, 10'h384, 10'h3e8
	};

	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : g_perm
			assign perm_tab[gi] = PERM_PACK[gi*10 +: 10];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// state
	fcr_pkg::fcr_state_s st_r;
	fcr_pkg::fcr_state_s st_nxt;

	logic             addr_ok;
	fcr_pkg::fcr_reg_e dec_sel;

	// only whole-word transfers reach the registers; others are accepted and dropped
	assign addr_ok = hsel && hready && htrans[1] && (hsize == `FCR_HSIZE_WORD);

	always_comb begin
		case (haddr[11:0])
			`FCR_ADDR_BRAKE: dec_sel = fcr_pkg::FCR_BRAKE;
			`FCR_ADDR_MOTOR: dec_sel = fcr_pkg::FCR_MOTOR;
			`FCR_ADDR_SPEED: dec_sel = fcr_pkg::FCR_SPEED;
			default:         dec_sel = fcr_pkg::FCR_NONE;
		endcase
	end

	always_comb begin
		st_nxt = st_r;
		// data phase of a pending write lands first
		case (st_r.wr_sel)
			fcr_pkg::FCR_BRAKE: st_nxt.brake = hwdata;
			fcr_pkg::FCR_MOTOR: st_nxt.motor = hwdata;
			fcr_pkg::FCR_SPEED: st_nxt.speed = hwdata;
			default:            st_nxt.brake = st_r.brake;
		endcase
		st_nxt.wr_sel = fcr_pkg::FCR_NONE;
		st_nxt.rdata  = 32'h00000000;
		if (addr_ok && hwrite) begin
			st_nxt.wr_sel = dec_sel;
		end else if (addr_ok) begin
			// read from the updated copy so a read right after a write sees it
			case (dec_sel)
				fcr_pkg::FCR_BRAKE: st_nxt.rdata = st_nxt.brake;
				fcr_pkg::FCR_MOTOR: st_nxt.rdata = st_nxt.motor;
				fcr_pkg::FCR_SPEED: st_nxt.rdata = st_nxt.speed;
				default:            st_nxt.rdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r.brake  <= `FCR_RST_VAL;
			st_r.motor  <= `FCR_RST_VAL;
			st_r.speed  <= `FCR_RST_VAL;
			st_r.wr_sel <= fcr_pkg::FCR_NONE;
			st_r.rdata  <= 32'h00000000;
		end else begin
			st_r <= st_nxt;
		end
	end

	// registers read zero for as long as reset is held
	a_reset_regs: assert property (@(posedge hclk)
		!hresetn ##1 !hresetn |-> (st_r.brake == `FCR_RST_VAL) && (st_r.motor == `FCR_RST_VAL) &&
		(st_r.speed == `FCR_RST_VAL) && (hrdata == 32'h00000000))
		else $error("registers not held at zero in reset");

	// zero wait states, never an error
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = st_r.rdata;

	// read data stands for the data phase only, zero otherwise
	a_rdata_idle: assert property (@(posedge hclk) disable iff (!hresetn)
		!(hsel && hready && htrans[1] && !hwrite && (hsize == `FCR_HSIZE_WORD)) |=>
		(hrdata == 32'h00000000))
		else $error("read data not zero outside a read");

	////////////////////////////////////////////////////////////////////////////
	// decoded configuration
	logic [23:0] brk_prod;
	logic [13:0] spd_fld;

	assign spd_fld  = st_r.speed[`FCR_MAXSPD_MSB:`FCR_MAXSPD_LSB];
	assign brk_prod = spd_fld * perm_tab[st_r.brake[`FCR_BRK_LVL_MSB:`FCR_BRK_LVL_LSB]];

	always_comb begin
		cfg.brake_level     = st_r.brake[`FCR_BRK_LVL_MSB:`FCR_BRK_LVL_LSB];
		cfg.brake_permille  = perm_tab[cfg.brake_level];
		// divide by constant; rounds the threshold down
		cfg.brake_speed_thr = 14'(brk_prod / `FCR_PERMILLE_FULL);
		cfg.phase_resistance_code  = st_r.brake[`FCR_RES_MSB:`FCR_RES_LSB];
		cfg.phase_inductance_code  = st_r.brake[`FCR_IND_MSB:`FCR_IND_LSB];
		cfg.back_emf_constant_code = st_r.motor[`FCR_BEMF_MSB:`FCR_BEMF_LSB];
		cfg.current_loop_prop_gain = st_r.motor[`FCR_CKP_MSB:`FCR_CKP_LSB];
		cfg.current_loop_int_gain  = st_r.motor[`FCR_CKI_MSB:`FCR_CKI_LSB];
		// either field at zero hands both gains to the automatic calculation
		cfg.curr_gain_auto = (cfg.current_loop_prop_gain == 10'h000) ||
			(cfg.current_loop_int_gain == 10'h000);
		cfg.speed_loop_prop_gain = {st_r.motor[`FCR_SKP_HI_MSB:`FCR_SKP_HI_LSB],
			st_r.speed[`FCR_SKP_LO_MSB:`FCR_SKP_LO_LSB]};
		cfg.speed_loop_int_gain = st_r.speed[`FCR_SKI_MSB:`FCR_SKI_LSB];
		cfg.max_speed    = spd_fld;
		cfg.max_speed_hz = 12'(spd_fld / `FCR_HZ_DIV);
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_wr(logic [11:0] a);
		hsel && hready && htrans[1] && hwrite && (hsize == `FCR_HSIZE_WORD) && (haddr[11:0] == a);
	endsequence

	sequence s_rd(logic [11:0] a);
		hsel && hready && htrans[1] && !hwrite && (hsize == `FCR_HSIZE_WORD) && (haddr[11:0] == a);
	endsequence

	// address phase taken, then the data phase that carries the word
	sequence s_wr_done(logic [11:0] a);
		s_wr(a) ##1 1'b1;
	endsequence

	// a write that must not touch any register: wrong size, or no register there
	sequence s_wr_drop;
		hsel && hready && htrans[1] && hwrite && ((hsize != `FCR_HSIZE_WORD) ||
		((haddr[11:0] != `FCR_ADDR_BRAKE) && (haddr[11:0] != `FCR_ADDR_MOTOR) &&
		(haddr[11:0] != `FCR_ADDR_SPEED)));
	endsequence

	// second copy of the brake table, written out code by code, so the
	// packed constant above is checked against something it was not built from
	function automatic logic [9:0] brake_pct_ref(input logic [3:0] code);
		case (code)
			4'h0:    brake_pct_ref = 10'h3e8;
			4'h1:    brake_pct_ref = 10'h384;
			4'h2:    brake_pct_ref = 10'h320;
			4'h3:    brake_pct_ref = 10'h2bc;
			4'h4:    brake_pct_ref = 10'h258;
			4'h5:    brake_pct_ref = 10'h1f4;
			4'h6:    brake_pct_ref = 10'h1c2;
			4'h7:    brake_pct_ref = 10'h190;
			4'h8:    brake_pct_ref = 10'h15e;
			4'h9:    brake_pct_ref = 10'h12c;
			4'ha:    brake_pct_ref = 10'h0fa;
			4'hb:    brake_pct_ref = 10'h0c8;
			4'hc:    brake_pct_ref = 10'h096;
			4'hd:    brake_pct_ref = 10'h064;
			4'he:    brake_pct_ref = 10'h032;
			default: brake_pct_ref = 10'h019;
		endcase
	endfunction

	a_brake_top_code: assert property (@(posedge hclk) disable iff (!hresetn)
		(cfg.brake_level == 4'h0) |-> (cfg.brake_permille == 10'h3e8))
		else $error("brake code 0 not full speed");

	a_brake_low_code: assert property (@(posedge hclk) disable iff (!hresetn)
		(cfg.brake_level == 4'hf) |-> (cfg.brake_permille == 10'h019) &&
		(cfg.brake_speed_thr == 14'(({10'h000, cfg.max_speed} * 24'h000019) / 24'h0003e8)))
		else $error("brake code f not 2.5 percent");

	a_res_ind_store: assert property (@(posedge hclk) disable iff (!hresetn)
		s_wr(`FCR_ADDR_BRAKE) ##1 1'b1 |=> (cfg.phase_resistance_code == $past(hwdata[15:8])) &&
		(cfg.phase_inductance_code == $past(hwdata[7:0])))
		else $error("resistance or inductance code not stored");

	a_bemf_store: assert property (@(posedge hclk) disable iff (!hresetn)
		s_wr(`FCR_ADDR_MOTOR) ##1 1'b1 |=> (cfg.back_emf_constant_code == $past(hwdata[30:23])) &&
		(cfg.current_loop_prop_gain == $past(hwdata[22:13])) &&
		(cfg.current_loop_int_gain == $past(hwdata[12:3])))
		else $error("motor register fields not stored");

	a_curr_auto_sel: assert property (@(posedge hclk) disable iff (!hresetn)
		s_wr(`FCR_ADDR_MOTOR) ##1 1'b1 |=> (cfg.curr_gain_auto ==
		(($past(hwdata[22:13]) == 10'h000) || ($past(hwdata[12:3]) == 10'h000))))
		else $error("auto gain select wrong");

	a_speed_kp_join: assert property (@(posedge hclk) disable iff (!hresetn)
		s_wr(`FCR_ADDR_SPEED) ##1 1'b1 |=> (cfg.speed_loop_prop_gain[6:0] == $past(hwdata[30:24])) &&
		(cfg.speed_loop_prop_gain[9:7] == $past(cfg.speed_loop_prop_gain[9:7])) &&
		(cfg.speed_loop_int_gain == $past(hwdata[23:14])))
		else $error("speed gain split wrong");

	a_reset_zero: assert property (@(posedge hclk)
		$rose(hresetn) |-> (st_r.motor == 32'h00000000) && (st_r.speed == 32'h00000000) &&
		(hrdata == 32'h00000000))
		else $error("registers not zero after reset");

	a_max_speed_hz: assert property (@(posedge hclk) disable iff (!hresetn)
		({2'h0, cfg.max_speed_hz} * 14'h0006 <= cfg.max_speed) &&
		(cfg.max_speed - {2'h0, cfg.max_speed_hz} * 14'h0006 < 14'h0006))
		else $error("top speed hertz wrong");

	a_read_back: assert property (@(posedge hclk) disable iff (!hresetn)
		s_rd(`FCR_ADDR_SPEED) |=> (hrdata == st_r.speed) ##1 (hreadyout == 1'b1))
		else $error("read data not register value");

	// each full-word write lands whole in its own register and nowhere else
	a_brake_word: assert property (@(posedge hclk) disable iff (!hresetn)
		s_wr_done(`FCR_ADDR_BRAKE) |=> (st_r.brake == $past(hwdata)))
		else $error("brake register word not stored");

	a_motor_word: assert property (@(posedge hclk) disable iff (!hresetn)
		s_wr_done(`FCR_ADDR_MOTOR) |=> (st_r.motor == $past(hwdata)))
		else $error("motor register word not stored");

	a_speed_word: assert property (@(posedge hclk) disable iff (!hresetn)
		s_wr_done(`FCR_ADDR_SPEED) |=> (st_r.speed == $past(hwdata)))
		else $error("speed register word not stored");

	a_brake_only: assert property (@(posedge hclk) disable iff (!hresetn)
		s_wr_done(`FCR_ADDR_BRAKE) |=> $stable(st_r.motor) && $stable(st_r.speed))
		else $error("brake write reached another register");

	a_motor_only: assert property (@(posedge hclk) disable iff (!hresetn)
		s_wr_done(`FCR_ADDR_MOTOR) |=> $stable(st_r.brake) && $stable(st_r.speed))
		else $error("motor write reached another register");

	a_speed_only: assert property (@(posedge hclk) disable iff (!hresetn)
		s_wr_done(`FCR_ADDR_SPEED) |=> $stable(st_r.brake) && $stable(st_r.motor))
		else $error("speed write reached another register");

	a_drop_keeps: assert property (@(posedge hclk) disable iff (!hresetn)
		s_wr_drop ##1 1'b1 |=> $stable(st_r.brake) && $stable(st_r.motor) && $stable(st_r.speed))
		else $error("dropped write changed a register");

	a_speed_hi_store: assert property (@(posedge hclk) disable iff (!hresetn)
		s_wr_done(`FCR_ADDR_MOTOR) |=> (cfg.speed_loop_prop_gain[9:7] == $past(hwdata[2:0])) &&
		(cfg.speed_loop_prop_gain[6:0] == $past(cfg.speed_loop_prop_gain[6:0])))
		else $error("motor write split speed gain wrong");

	a_max_speed_store: assert property (@(posedge hclk) disable iff (!hresetn)
		s_wr_done(`FCR_ADDR_SPEED) |=> (cfg.max_speed == $past(hwdata[13:0])))
		else $error("top speed field not stored");

	a_hz_store: assert property (@(posedge hclk) disable iff (!hresetn)
		s_wr_done(`FCR_ADDR_SPEED) |=> (cfg.max_speed_hz == 12'($past(hwdata[13:0]) / 14'h0006)))
		else $error("top speed hertz not from written field");

	a_brake_level_store: assert property (@(posedge hclk) disable iff (!hresetn)
		s_wr_done(`FCR_ADDR_BRAKE) |=> (cfg.brake_level == $past(hwdata[19:16])))
		else $error("brake level code not stored");

	// read data is the register as it stands after any write ahead of it
	a_read_brake: assert property (@(posedge hclk) disable iff (!hresetn)
		s_rd(`FCR_ADDR_BRAKE) |=> (hrdata == st_r.brake))
		else $error("brake read data not register value");

	a_read_motor: assert property (@(posedge hclk) disable iff (!hresetn)
		s_rd(`FCR_ADDR_MOTOR) |=> (hrdata == st_r.motor))
		else $error("motor read data not register value");

	a_read_hole: assert property (@(posedge hclk) disable iff (!hresetn)
		hsel && hready && htrans[1] && !hwrite && (haddr[11:0] != `FCR_ADDR_BRAKE) &&
		(haddr[11:0] != `FCR_ADDR_MOTOR) && (haddr[11:0] != `FCR_ADDR_SPEED) |=> (hrdata == 32'h00000000))
		else $error("read of a hole not zero");

	a_brake_table: assert property (@(posedge hclk) disable iff (!hresetn)
		cfg.brake_permille == brake_pct_ref(cfg.brake_level))
		else $error("brake percent code mismatch");

	a_brake_thr_bound: assert property (@(posedge hclk) disable iff (!hresetn)
		cfg.brake_speed_thr <= cfg.max_speed)
		else $error("brake threshold above top speed");

endmodule // fcr_regs
`default_nettype wire

/* File: fcr_regs_tb.sv */
// self-checking bench for the closed-loop configuration register bank
`timescale 1ns/10ps
`default_nettype none
`include "fcr_defs.svh"
module fcr_regs_tb;
	logic              hclk;
	logic              hresetn;
	logic              hsel;
	logic [31:0]       haddr;
	logic [1:0]        htrans;
	logic              hwrite;
	logic [2:0]        hsize;
	logic [31:0]       hwdata;
	wire logic         hready;
	logic              hreadyout;
	logic              hresp;
	logic [31:0]       hrdata;
	fcr_pkg::fcr_cfg_s cfg;
	int                miscompares;
	int                check_count;
	logic [31:0]       mdl[3];
	logic [31:0]       adr[3] = '{{20'h0, `FCR_ADDR_BRAKE}, {20'h0, `FCR_ADDR_MOTOR}, {20'h0, `FCR_ADDR_SPEED}};
	int                pct[$] = {1000, 900, 800, 700, 600, 500, 450, 400, 350, 300, 250, 200, 150, 100, 50, 25};

	// single slave, so its ready is the bus ready
	assign hready = hreadyout;

	fcr_regs fcr_regs_i (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hready),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.hrdata    (hrdata),
		.cfg       (cfg)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one single transfer; waits on ready, no fixed latency assumed
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [2:0] sz,
		output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= sz;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask

	// expected decode worked out from the model registers
	task automatic cfg_chk;
		logic [31:0] b;
		logic [31:0] m;
		logic [31:0] s;
		int          ms;
		#1;
		b = mdl[0];
		m = mdl[1];
		s = mdl[2];
		ms = s[13:0];
		chk("brake_level", b[19:16], cfg.brake_level);
		chk("brake_permille", pct[b[19:16]], cfg.brake_permille);
		chk("brake_speed_thr", ms * pct[b[19:16]] / 1000, cfg.brake_speed_thr);
		chk("resistance", b[15:8], cfg.phase_resistance_code);
		chk("inductance", b[7:0], cfg.phase_inductance_code);
		chk("back_emf", m[30:23], cfg.back_emf_constant_code);
		chk("cur_kp", m[22:13], cfg.current_loop_prop_gain);
		chk("cur_ki", m[12:3], cfg.current_loop_int_gain);
		chk("cur_auto", (m[22:13] == 0) || (m[12:3] == 0), cfg.curr_gain_auto);
		chk("spd_kp", {m[2:0], s[30:24]}, cfg.speed_loop_prop_gain);
		chk("spd_ki", s[23:14], cfg.speed_loop_int_gain);
		chk("max_speed", ms, cfg.max_speed);
		chk("max_speed_hz", ms / 6, cfg.max_speed_hz);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end

	initial begin
		repeat (5000) @(posedge hclk);
		miscompares++;
		report_and_stop();
	end

	initial begin
		logic [31:0] rd;
		logic [31:0] w;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h0;
		hwdata = 32'h0;
		mdl = '{default: 32'h0};
		void'($urandom(32'hf3df0978));
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		cfg_chk();
		for (int k = 0; k < 3; k++) begin
			bus(1'b0, adr[k], 32'h0, 3'h2, rd);
			chk("reset_value", `FCR_RST_VAL, rd);
		end
		// every brake level code, gain fields zeroed in turn
		for (int i = 0; i < 16; i++) begin
			for (int k = 0; k < 3; k++) begin
				w = $urandom;
				if (k == 0)
					w[19:16] = i[3:0];
				if (k == 1 && i % 3 == 1)
					w[22:13] = 10'h0;
				if (k == 1 && i % 3 == 2)
					w[12:3] = 10'h0;
				bus(1'b1, adr[k], w, 3'h2, rd);
				mdl[k] = w;
				bus(1'b0, adr[k], 32'h0, 3'h2, rd);
				chk("readback", mdl[k], rd);
			end
			cfg_chk();
		end
		// refused accesses: byte size and a hole between registers
		bus(1'b1, adr[1], ~mdl[1], 3'h0, rd);
		bus(1'b1, 32'h0000022c, 32'hffffffff, 3'h2, rd);
		bus(1'b0, 32'h0000022c, 32'h0, 3'h2, rd);
		chk("unmapped", 32'h0, rd);
		bus(1'b0, adr[1], 32'h0, 3'h2, rd);
		chk("byte_write_dropped", mdl[1], rd);
		cfg_chk();
		// mid-run reset must clear everything written so far
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		mdl = '{default: 32'h0};
		cfg_chk();
		for (int k = 0; k < 3; k++) begin
			bus(1'b0, adr[k], 32'h0, 3'h2, rd);
			chk("reset_again", `FCR_RST_VAL, rd);
		end
		report_and_stop();
	end
endmodule // fcr_regs_tb
`default_nettype wire
